// ---- src/rst_seq_pkg.sv ----
// constants and types shared by the reset pin sequencer
package rst_seq_pkg;
    localparam int unsigned CNT_W            = 10;
    localparam int unsigned STRETCH_CYCLES   = 512;
    localparam int unsigned RELEASE_CYCLES   = 10;
    localparam int unsigned FIRST_BUS_CYCLES = 10;
    localparam int unsigned MIN_LOW_CYCLES   = 4;
    localparam int unsigned BUS_MON_CYCLES   = 64;
    localparam logic        PIN_SYNC_RESET   = 1'b1;

    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_POSTPONE = 7'h02,
        ST_EXT_WAIT = 7'h04,
        ST_DRIVE    = 7'h08,
        ST_RELEASE  = 7'h10,
        ST_MODE_SEL = 7'h20,
        ST_BUS_WAIT = 7'h40
    } seq_state_e;
endpackage

// ---- src/phase_cnt_if.sv ----
// carrier between the sequencer and its phase counter
`timescale 1ns/1ps
interface phase_cnt_if #(parameter int unsigned W = rst_seq_pkg::CNT_W);
    logic         clear;
    logic         enable;
    logic [W-1:0] count;
    modport ctrl (output clear, output enable, input count);
    modport cnt  (input clear, input enable, output count);
endinterface

// ---- src/phase_counter.sv ----
// phase cycle counter, restarted at the start of every phase except the first-bus wait
`timescale 1ns/1ps
module phase_counter #(
    parameter int unsigned W = rst_seq_pkg::CNT_W
) (
    input  wire logic sys_clk,  // system clock
    input  wire logic rst_n,    // async reset, active low
    phase_cnt_if.cnt  pc        // clear, enable and count
);
    typedef struct packed {
        logic [W-1:0] count;
    } cnt_state_s;

    cnt_state_s st_reg;
    cnt_state_s st_next;

    always_comb begin
        st_next = st_reg;
        if (pc.clear) begin
            st_next.count = '0;
        end else if (pc.enable) begin
            st_next.count = W'(st_reg.count + 1'b1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pc.count = st_reg.count;
endmodule // phase_counter

// ---- src/reset_pin_sequencer.sv ----
// reset pin sequencer: stretch, release, retest and hand-over to start-up
// What this block does
// - postpone the pin drive until bus cycle ends or monitor timeout; reset_active rises at once
// - latch a long enough external request
// - drive 512 cycles after external release
// - internal reset drives pin 512 cycles minimum
// - keep driving while internal request persists
// - release pin ten cycles before sampling
// - pin high at test starts exception processing
// - pin low at test repeats drive/release
// - integration pins inactive while reset active
// - mode selection first, then exception processing
// - outputs function only after reset release
// - module pins default to input ports
// - port pins go high-impedance after reset
// - first bus cycle ten cycles after release
// - reset cause updated at reset release, once the pin tests high
`timescale 1ns/1ps
module reset_pin_sequencer #(
    parameter int unsigned MIN_LOW = rst_seq_pkg::MIN_LOW_CYCLES, // least external low
    parameter int unsigned BUS_MON = rst_seq_pkg::BUS_MON_CYCLES  // bus monitor timeout
) (
    input  wire logic sys_clk,           // 20 MHz clock, one output-clock cycle each
    input  wire logic rst_n,             // async reset, active low
    input  wire logic reset_pin_in,      // level read from the reset pin
    output logic      reset_pin_out,     // pin drive value, always low
    output logic      reset_pin_oe,      // high while this block pulls the pin low
    input  wire logic internal_req,      // internal reset request, same clock
    input  wire logic bus_cycle_end,     // current bus cycle finished or bus idle
    output logic      reset_active,      // system in reset
    output logic      pins_inactive,     // integration pins to inactive / high-z
    output logic      port_defaults,     // module pins to input ports, dirs cleared
    output logic      outputs_enable,    // output pins may run their function
    output logic      mode_select,       // one-cycle strobe: sample mode pins
    output logic      exception_start,   // one-cycle strobe: begin reset exception
    output logic      first_bus_cycle,   // one-cycle strobe: first bus cycle may start
    output logic      cause_update,      // one-cycle strobe: cause bits updated
    output logic      cause_external,    // last reset had an external source
    output logic      cause_internal     // last reset had an internal source
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        rst_seq_pkg::seq_state_e state;
        logic [2:0]  pin_sync;
        logic        pin_level;
        logic [15:0] low_cnt;
        logic [15:0] mon_cnt;
        logic        ext_latch;
        logic        int_seen;
        logic        cause_ext;
        logic        cause_int;
        logic        cause_strobe;
        logic        except_strobe;
        logic        bus_strobe;
    } seq_s;

    seq_s st_reg;
    seq_s st_next;

    phase_cnt_if #(.W(rst_seq_pkg::CNT_W)) pc ();

    phase_counter #(.W(rst_seq_pkg::CNT_W)) u_phase_counter (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .pc      (pc.cnt)
    );

    localparam logic [rst_seq_pkg::CNT_W-1:0] STRETCH_LAST =
        rst_seq_pkg::CNT_W'(rst_seq_pkg::STRETCH_CYCLES - 1);
    localparam logic [rst_seq_pkg::CNT_W-1:0] RELEASE_LAST =
        rst_seq_pkg::CNT_W'(rst_seq_pkg::RELEASE_CYCLES - 1);
    localparam logic [rst_seq_pkg::CNT_W-1:0] BUS_LAST =
        rst_seq_pkg::CNT_W'(rst_seq_pkg::FIRST_BUS_CYCLES - 1);
    localparam logic [15:0] MIN_LOW_LAST = 16'(MIN_LOW - 1);
    localparam logic [15:0] BUS_MON_LAST = 16'(BUS_MON - 1);

    logic enter_phase;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        st_next.cause_strobe  = 1'b0;
        st_next.except_strobe = 1'b0;
        st_next.bus_strobe    = 1'b0;
        pc.enable = 1'b0;

        // three stages; a change counts once stages two and three agree
        st_next.pin_sync = {st_reg.pin_sync[1:0], reset_pin_in};
        if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
            st_next.pin_level = st_reg.pin_sync[2];
        end

        // a short glitch on the pin never reaches the latch
        if (st_reg.pin_level || st_reg.state != rst_seq_pkg::ST_IDLE) begin
            st_next.low_cnt = '0;
        end else if (st_reg.low_cnt != MIN_LOW_LAST) begin
            st_next.low_cnt = 16'(st_reg.low_cnt + 1'b1);
        end

        if (internal_req) begin
            st_next.int_seen = 1'b1;
        end

        case (st_reg.state)
            rst_seq_pkg::ST_IDLE: begin
                st_next.mon_cnt = '0;
                if (!st_reg.pin_level && st_reg.low_cnt == MIN_LOW_LAST) begin
                    st_next.ext_latch = 1'b1;
                    st_next.state     = rst_seq_pkg::ST_POSTPONE;
                end else if (internal_req) begin
                    st_next.state = rst_seq_pkg::ST_POSTPONE;
                end
            end
            rst_seq_pkg::ST_POSTPONE: begin
                // lets a write in flight finish; the monitor bounds the wait
                st_next.mon_cnt = 16'(st_reg.mon_cnt + 1'b1);
                if (bus_cycle_end || st_reg.mon_cnt == BUS_MON_LAST) begin
                    st_next.state = st_reg.ext_latch ? rst_seq_pkg::ST_EXT_WAIT
                                                     : rst_seq_pkg::ST_DRIVE;
                end
            end
            rst_seq_pkg::ST_EXT_WAIT: begin
                if (st_reg.pin_level) begin
                    st_next.state = rst_seq_pkg::ST_DRIVE;
                end
            end
            rst_seq_pkg::ST_DRIVE: begin
                pc.enable = (pc.count != STRETCH_LAST);
                if (pc.count == STRETCH_LAST && !internal_req) begin
                    st_next.state = rst_seq_pkg::ST_RELEASE;
                end
            end
            rst_seq_pkg::ST_RELEASE: begin
                pc.enable = 1'b1;
                if (pc.count == RELEASE_LAST) begin
                    if (st_reg.pin_level) begin
                        st_next.state        = rst_seq_pkg::ST_MODE_SEL;
                        st_next.cause_ext    = st_reg.ext_latch;
                        st_next.cause_int    = st_reg.int_seen;
                        st_next.cause_strobe = 1'b1;
                        st_next.ext_latch    = 1'b0;
                        st_next.int_seen     = internal_req;
                    end else begin
                        st_next.state = rst_seq_pkg::ST_DRIVE;
                    end
                end
            end
            rst_seq_pkg::ST_MODE_SEL: begin
                pc.enable             = 1'b1;
                st_next.except_strobe = 1'b1;
                st_next.state         = rst_seq_pkg::ST_BUS_WAIT;
            end
            rst_seq_pkg::ST_BUS_WAIT: begin
                pc.enable = 1'b1;
                if (pc.count == BUS_LAST) begin
                    st_next.bus_strobe = 1'b1;
                    st_next.state      = rst_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                st_next.state = rst_seq_pkg::ST_DRIVE;
            end
        endcase

        // first-bus wait runs on from the restart at mode select, so the bus
        // strobe lands ten cycles after the mode select strobe
        enter_phase = (st_next.state != st_reg.state) &&
                      (st_next.state != rst_seq_pkg::ST_BUS_WAIT);
        pc.clear = enter_phase;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg               <= '0;
            st_reg.state         <= rst_seq_pkg::ST_DRIVE;
            st_reg.pin_sync      <= {3{rst_seq_pkg::PIN_SYNC_RESET}};
            st_reg.pin_level     <= rst_seq_pkg::PIN_SYNC_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic in_reset;
    assign in_reset = (st_reg.state != rst_seq_pkg::ST_IDLE) &&
                      (st_reg.state != rst_seq_pkg::ST_MODE_SEL) &&
                      (st_reg.state != rst_seq_pkg::ST_BUS_WAIT);

    assign reset_pin_out   = 1'b0;
    assign reset_pin_oe    = (st_reg.state == rst_seq_pkg::ST_DRIVE);
    assign reset_active    = in_reset;
    assign pins_inactive   = in_reset;
    assign port_defaults   = in_reset;
    assign outputs_enable  = !in_reset;
    assign mode_select     = (st_reg.state == rst_seq_pkg::ST_MODE_SEL);
    assign exception_start = st_reg.except_strobe;
    assign first_bus_cycle = st_reg.bus_strobe;
    assign cause_update    = st_reg.cause_strobe;
    assign cause_external  = st_reg.cause_ext;
    assign cause_internal  = st_reg.cause_int;
endmodule // reset_pin_sequencer

// ---- bench/reset_pin_sequencer_assertions.sv ----
// concurrent checks on the reset pin sequencer ports
`timescale 1ns/1ps
module reset_pin_sequencer_assertions (
    input wire logic sys_clk,         // clock
    input wire logic rst_n,           // reset, active low
    input wire logic reset_pin_out,   // pin drive value
    input wire logic reset_pin_oe,    // pin pulled low
    input wire logic internal_req,    // internal request
    input wire logic reset_active,    // in reset
    input wire logic pins_inactive,   // pins inactive
    input wire logic port_defaults,   // port defaults
    input wire logic outputs_enable,  // outputs run
    input wire logic mode_select,     // mode strobe
    input wire logic exception_start, // exception strobe
    input wire logic first_bus_cycle, // bus strobe
    input wire logic cause_update     // cause strobe
);
    logic [10:0] hi_cnt;
    // length of the current drive run, so the stretch can be judged when it ends
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) hi_cnt <= 11'h000;
        else hi_cnt <= reset_pin_oe ? hi_cnt + 11'h001 : 11'h000;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence release_win;
        (!reset_pin_oe && reset_active)[*8] ##1 (!reset_pin_oe && reset_active)[*2];
    endsequence
    chk_drive_len: assert property ($fell(reset_pin_oe) |-> hi_cnt >= 11'h200)
        else $error("drive phase shorter than the stretch");
    chk_release_len: assert property ($fell(reset_pin_oe) |-> release_win)
        else $error("release window not ten cycles");
    chk_retest_step: assert property ($fell(reset_pin_oe) ##0 release_win |=> reset_pin_oe || mode_select)
        else $error("no decision after the release window");
    chk_int_hold: assert property (internal_req && reset_pin_oe |=> reset_pin_oe)
        else $error("pin released while internal request active");
    chk_mode_exc: assert property (mode_select |=> exception_start && !mode_select)
        else $error("exception start not after mode select");
    chk_cause_upd: assert property (mode_select |-> cause_update && !reset_active)
        else $error("cause not updated at release");
    chk_first_bus: assert property (mode_select |-> ##10 first_bus_cycle)
        else $error("first bus cycle not ten cycles after release");
    chk_pins_state: assert property (reset_active |-> pins_inactive && port_defaults && !outputs_enable)
        else $error("pins not inactive during reset");
    chk_pin_low: assert property (reset_pin_oe |-> !reset_pin_out && reset_active)
        else $error("pin driven without reset");
endmodule // reset_pin_sequencer_assertions

// ---- bench/reset_line_model.sv ----
// external reset source sharing the open-drain reset line
`timescale 1ns/1ps
module reset_line_model (
    input  wire logic sys_clk,  // clock
    input  wire logic hold_low, // command: request reset
    output logic      pull_oe   // high while pulling the line low
);
    // only pulls low; the pull-up gives the high level, so no stale value remains
    always_ff @(posedge sys_clk) pull_oe <= hold_low;
endmodule // reset_line_model

// ---- bench/reset_pin_sequencer_test.sv ----
// self-checking testbench of the reset pin sequencer
`timescale 1ns/1ps
module reset_pin_sequencer_test;
    logic sys_clk = 1'b0, rst_n = 1'b0, internal_req = 1'b0, bus_cycle_end = 1'b0;
    logic hold_low = 1'b0, pull_oe, reset_pin_out, reset_pin_oe, reset_active, pins_inactive;
    logic port_defaults, outputs_enable, mode_select, exception_start, first_bus_cycle;
    logic cause_update, cause_external, cause_internal, pin_level;
    logic [31:0] rnd = 32'hE522;
    logic [1:0]  cause_q[$];
    logic [23:0] len_q[$];
    int fails = 0, n_compared = 0, run = 0;
    // wired-and line with pull-up: any party pulling low wins
    assign pin_level = !((reset_pin_oe === 1'b1 && reset_pin_out === 1'b0) || pull_oe === 1'b1);
    always #25 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    always @(posedge sys_clk) begin
        rnd <= lfsr(rnd);
        bus_cycle_end <= rnd[3];
    end
    reset_pin_sequencer DUT (.sys_clk(sys_clk), .rst_n(rst_n),
        .reset_pin_in(pin_level), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .internal_req(internal_req), .bus_cycle_end(bus_cycle_end), .reset_active(reset_active),
        .pins_inactive(pins_inactive), .port_defaults(port_defaults),
        .outputs_enable(outputs_enable), .mode_select(mode_select),
        .exception_start(exception_start), .first_bus_cycle(first_bus_cycle),
        .cause_update(cause_update), .cause_external(cause_external),
        .cause_internal(cause_internal));
    reset_line_model line_src (.sys_clk(sys_clk), .hold_low(hold_low), .pull_oe(pull_oe));
    ////////////////////////////////////////////////////////////////////////////
    task automatic miss(input logic [23:0] e, input logic [23:0] g);
        fails++;
        $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    endtask
    task automatic cmp_cause(input logic [1:0] e, input logic [1:0] g);
        n_compared++;
        if (g !== e) miss({22'h0, e}, {22'h0, g});
    endtask
    task automatic cmp_flag(input logic e, input logic g);
        n_compared++;
        if (g !== e) miss({23'h0, e}, {23'h0, g});
    endtask
    task automatic cmp_len(input logic [23:0] e, input logic [11:0] g);
        n_compared++;
        if (!(g >= e[23:12] && g <= e[11:0])) miss(e, {12'h0, g});
    endtask
    // one drive run ends when the pin drive drops: its length goes against the oldest note
    always @(posedge sys_clk) if (rst_n === 1'b1) begin
        if (reset_pin_oe === 1'b1) run++;
        else if (run != 0) begin
            cmp_len(len_q.size() ? len_q.pop_front() : 24'h0, run[11:0]);
            run = 0;
        end
        if (mode_select === 1'b1)
            cmp_cause(cause_q.size() ? cause_q.pop_front() : 2'h3, {cause_external, cause_internal});
    end
    task automatic wait_oe();
        for (int i = 0; i < 100 && reset_pin_oe !== 1'b1; i++) @(posedge sys_clk);
    endtask
    task automatic wait_seq(input string name);
        int i;
        for (i = 0; i < 3000 && mode_select !== 1'b1; i++) @(posedge sys_clk);
        if (i == 3000) fails++;
        repeat (15) @(posedge sys_clk);
        $display("test %0s done", name);
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        results();
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        len_q.push_back({12'h200, 12'h201});
        cause_q.push_back(2'h0);
        wait_seq("power_up");
        repeat (rnd[4:0]) @(posedge sys_clk);
        len_q.push_back({12'h200, 12'h200});
        cause_q.push_back(2'h1);
        internal_req <= 1'b1;
        @(posedge sys_clk) internal_req <= 1'b0;
        wait_seq("internal_pulse");
        len_q.push_back({12'h258, 12'h25D});
        cause_q.push_back(2'h1);
        internal_req <= 1'b1;
        wait_oe();
        repeat (600) @(posedge sys_clk);
        internal_req <= 1'b0;
        wait_seq("internal_hold");
        len_q.push_back({12'h200, 12'h200});
        cause_q.push_back(2'h2);
        hold_low <= 1'b1;
        repeat (20) @(posedge sys_clk);
        hold_low <= 1'b0;
        wait_seq("external");
        // line held low by the far side over the first release window forces a second stretch
        len_q.push_back({12'h200, 12'h200});
        len_q.push_back({12'h200, 12'h200});
        cause_q.push_back(2'h1);
        internal_req <= 1'b1;
        @(posedge sys_clk) internal_req <= 1'b0;
        wait_oe();
        hold_low <= 1'b1;
        repeat (530) @(posedge sys_clk);
        hold_low <= 1'b0;
        wait_seq("retest");
        // a one-cycle glitch is below the minimum low time and must start nothing
        hold_low <= 1'b1;
        @(posedge sys_clk) hold_low <= 1'b0;
        repeat (80) @(posedge sys_clk);
        cmp_flag(1'b0, reset_active);
        cmp_flag(1'b0, len_q.size() != 0 || cause_q.size() != 0);
        $display("test glitch done");
        results();
    end
endmodule // reset_pin_sequencer_test
bind reset_pin_sequencer reset_pin_sequencer_assertions u_chk (.sys_clk(sys_clk),
    .rst_n(rst_n), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .internal_req(internal_req), .reset_active(reset_active), .pins_inactive(pins_inactive),
    .port_defaults(port_defaults), .outputs_enable(outputs_enable), .mode_select(mode_select),
    .exception_start(exception_start), .first_bus_cycle(first_bus_cycle),
    .cause_update(cause_update));
